// ### bench/pgio_pin_model.sv
// board-side model of the seven port pins
`timescale 1ns/100ps
`default_nettype none
module pgio_pin_model (
	// block side
	input wire logic [6:0] pin_out,
	input wire logic [6:0] pin_oe_b,
	// board side
	input wire logic [6:0] board_val,
	output logic [6:0] pin_in
);
	// the board drives only the pins that the block has released
	assign pin_in = (pin_out & ~pin_oe_b) | (board_val & pin_oe_b);
endmodule
`default_nettype wire

// ### bench/test_pgio_port.sv
// testbench for the port g block
`timescale 1ns/100ps
`default_nettype none
module test_pgio_port;
	import pgio_pkg::*;
	logic ref_clk, rst_b, ext_en, reg_wr, reg_rd, bus_ack, brq_out, sel4, bus_req_in;
	logic [2:0] mode, reg_addr;
	logic [7:0] reg_wdata, reg_rdata;
	logic [3:0] area_sel;
	logic [1:0] row_req, dram_type;
	logic [6:0] pin_in, pin_out, pin_oe_b, board_val;
	logic [2:0] modes [4] = '{PGIO_MODE1, PGIO_MODE2, PGIO_MODE4, PGIO_MODE7};
	int err_total, n_compared;
	// ==============================
	// instances
	pgio_port dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .op_mode(mode),
		.external_expansion_enable(ext_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_ack(bus_ack),
		.bus_request_out(brq_out), .select_four_req(sel4), .area_select_req(area_sel),
		.row_strobe_req(row_req), .dram_area_type(dram_type), .bus_request_in(bus_req_in),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe_b(pin_oe_b));
	pgio_pin_model pins_u (.pin_out(pin_out), .pin_oe_b(pin_oe_b), .board_val(board_val),
		.pin_in(pin_in));
	initial begin
		ref_clk = 1'h0;
		forever #5 ref_clk = ~ref_clk;
	end
	// ==============================
	// tasks
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge ref_clk);
		reg_wr <= 1'h0;
	endtask
	task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge ref_clk);
		reg_rd <= 1'h0;
		#1 chk(reg_rdata, exp);
	endtask
	// settle through the synchronisers, then compare enables and driven levels
	task automatic pchk(input logic [6:0] exp_oe, input logic [6:0] exp_lvl);
		repeat (5) @(posedge ref_clk);
		#1 chk({1'h0, pin_oe_b}, {1'h0, exp_oe});
		chk({1'h0, pin_out | pin_oe_b}, {1'h0, exp_lvl});
	endtask
	task automatic boot(input logic [2:0] m, input logic e);
		@(posedge ref_clk);
		rst_b <= 1'h0;
		mode <= m;
		ext_en <= e;
		bus_ack <= 1'h0;
		brq_out <= 1'h0;
		area_sel <= 4'h0;
		row_req <= 2'h0;
		repeat (8) @(posedge ref_clk);
		rst_b <= 1'h1;
		repeat (2) @(posedge ref_clk);
	endtask
	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// ==============================
	// sequence
	initial begin
		#300000;
		err_total++;
		conclude();
	end
	initial begin
		{rst_b, ext_en, reg_wr, reg_rd, bus_ack, brq_out, sel4} = 7'h00;
		mode = PGIO_MODE1;
		reg_addr = 3'h0;
		reg_wdata = 8'h00;
		area_sel = 4'h0;
		row_req = 2'h0;
		dram_type = 2'h1;
		board_val = 7'h00;
		err_total = 0;
		n_compared = 0;
		for (int i = 0; i < 4; i++) begin
			boot(modes[i], modes[i] == PGIO_MODE7);
			rdc(PGIO_OFS_DIR, (i < 2) ? 8'h01 : 8'h00);
			pchk((i < 2) ? 7'h7E : 7'h7F, (i < 2) ? 7'h7E : 7'h7F);
			rdc(PGIO_OFS_LATCH, 8'h00);
			wr(PGIO_OFS_LATCH, 8'hFF);
			wr(PGIO_OFS_DIR, 8'h09);
			wr(PGIO_OFS_BUSCFG, 8'h7B);
			pchk(7'h42, 7'h42);
			chk({7'h00, bus_req_in}, 8'h00);
			rdc(PGIO_OFS_PINS, 8'h09);
			@(posedge ref_clk);
			bus_ack <= 1'h1;
			brq_out <= 1'h1;
			area_sel <= 4'h8;
			row_req <= 2'h1;
			pchk(7'h42, 7'h7E);
			rdc(PGIO_OFS_PINS, 8'h3D);
			wr(PGIO_OFS_BUSCFG, 8'h04);
			wr(PGIO_OFS_DIR, 8'h10);
			pchk(7'h6F, 7'h6F);
			chk({7'h00, bus_req_in}, 8'h01);
			$display("test %0d done", i);
		end
		boot(PGIO_MODE7, 1'h0);
		wr(PGIO_OFS_LATCH, 8'hFF);
		rdc(PGIO_OFS_LATCH, 8'h7F);
		wr(PGIO_OFS_DIR, 8'h0F);
		wr(PGIO_OFS_BUSCFG, 8'h7F);
		board_val <= 7'h15;
		pchk(7'h70, 7'h7F);
		rdc(PGIO_OFS_PINS, 8'h1F);
		wr(PGIO_OFS_PINS, 8'h00);
		rdc(PGIO_OFS_PINS, 8'h1F);
		chk({7'h00, bus_req_in}, 8'h01);
		rdc(3'h7, 8'h00);
		$display("test 4 done");
		conclude();
	end
endmodule
`default_nettype wire

// ### design/pgio_pkg.sv
// package: register map, field layout, reset values and modes of the port g block
package pgio_pkg;
	// register indices on the plain port (no offsets printed)
	localparam logic [2:0] PGIO_OFS_LATCH = 3'h0;
	localparam logic [2:0] PGIO_OFS_PINS = 3'h1;
	localparam logic [2:0] PGIO_OFS_DIR = 3'h2;
	localparam logic [2:0] PGIO_OFS_BUSCFG = 3'h3;
	localparam logic [2:0] PGIO_OFS_MODE = 3'h4;
	// reset values
	localparam logic [6:0] PGIO_LATCH_RST = 7'h00;
	localparam logic [6:0] PGIO_DIR_RST = 7'h00;
	localparam logic [7:0] PGIO_BUSCFG_RST = 8'h00;
	// bus configuration register fields
	localparam int PGIO_CFG_BUS_RELEASE_ENABLE = 0;
	localparam int PGIO_CFG_BREQOE = 1;
	localparam int PGIO_CFG_SELECT4_ENABLE = 2;
	localparam int PGIO_CFG_CS0E = 3;
	localparam int PGIO_CFG_CS1E = 4;
	localparam int PGIO_CFG_CS2E = 5;
	localparam int PGIO_CFG_CS3E = 6;
	// mode register fields
	localparam int PGIO_MODE_EXTERNAL_EXPANSION_ENABLE = 3;
	localparam int PGIO_PIN0 = 0;
	// operating modes
	localparam logic [2:0] PGIO_MODE1 = 3'h1;
	localparam logic [2:0] PGIO_MODE2 = 3'h2;
	localparam logic [2:0] PGIO_MODE4 = 3'h4;
	localparam logic [2:0] PGIO_MODE7 = 3'h7;

	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} pgio_req_s;

	typedef struct packed {
		logic bus_release_enable;
		logic bus_request_out_enable;
		logic select4_enable;
		logic [3:0] select_n_enable;
	} pgio_cfg_s;
endpackage

// ### design/pgio_port.sv
// port g: output latch, pin-state read path and bus-control pin multiplexer
//
// Contract
// - latch holds seven read/write bits, reset zero, driven on general output pins
// - latch bit 7 reads zero and ignores writes
// - pin-state register is read only; writes change nothing
// - pin-state bit 7 is undefined; driven as zero here
// - direction 1: pin-state read returns the latch bit
// - direction 0: pin-state read returns the sampled pin level
// - pin 6 is bus request input when release enabled in external modes
// - pin 5 is bus acknowledge output when release enabled in external modes
// - pin 4: request output first, else select four when enabled and direction 1
// - pins 3,2: select on direction 1 in normal area; row strobe in dram area
// - pins 1,0: select when enable and direction both 1, else general io
// - mode 7 without expansion: all pins general io by direction bits
// - pin 0 direction resets 1 in modes 1,2 and 0 in modes 4,7
`timescale 1ns/100ps
`default_nettype none
module pgio_port
	import pgio_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// strap inputs
	input wire logic [2:0] op_mode,
	input wire logic external_expansion_enable,
	// register port
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// bus controller side
	input wire logic bus_ack,
	input wire logic bus_request_out,
	input wire logic select_four_req,
	input wire logic [3:0] area_select_req,
	input wire logic [1:0] row_strobe_req,
	input wire logic [1:0] dram_area_type,
	output logic bus_request_in,
	// pins
	input wire logic [6:0] pin_in,
	output logic [6:0] pin_out,
	output logic [6:0] pin_oe_b
);
	pgio_req_s req;
	logic [6:0] port_output_latch_q;
	logic [6:0] port_direction_bits_q;
	pgio_cfg_s cfg_q;
	logic [6:0] pin_meta_q;
	logic [6:0] pin_sync_q;
	logic [2:0] mode_q;
	logic external_expansion_enable_q;
	logic strap_done_q;
	logic ext_bus;
	logic release_on;
	logic [6:0] func_drive;
	logic [6:0] func_val;
	logic [6:0] gpio_mask;
	logic [6:0] pin_out_d;
	logic [6:0] oe_b_d;
	logic [6:0] pin_state;

	assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

	function automatic logic is_ext(input logic [2:0] m, input logic e);
		is_ext = (m == PGIO_MODE1) || (m == PGIO_MODE2) || (m == PGIO_MODE4) ||
			((m == PGIO_MODE7) && e);
	endfunction

	// ==========================================================
	// strap capture after reset release
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_q <= PGIO_MODE7;
			external_expansion_enable_q <= 1'b0;
			strap_done_q <= 1'b0;
		end else if (!strap_done_q) begin
			mode_q <= op_mode;
			external_expansion_enable_q <= external_expansion_enable;
			strap_done_q <= 1'b1;
		end
	end

	// ==========================================================
	// pin synchroniser
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_meta_q <= 7'h00;
			pin_sync_q <= 7'h00;
		end else begin
			pin_meta_q <= pin_in;
			pin_sync_q <= pin_meta_q;
		end
	end

	// ==========================================================
	// registers
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			port_output_latch_q <= PGIO_LATCH_RST;
		end else if (req.wr && req.addr == PGIO_OFS_LATCH) begin
			port_output_latch_q <= req.wdata[6:0];
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			port_direction_bits_q <= PGIO_DIR_RST;
		end else if (!strap_done_q) begin
			// pin 0 direction depends on the captured mode
			port_direction_bits_q[PGIO_PIN0] <= (op_mode == PGIO_MODE1) ||
				(op_mode == PGIO_MODE2);
		end else if (req.wr && req.addr == PGIO_OFS_DIR) begin
			port_direction_bits_q <= req.wdata[6:0];
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cfg_q <= pgio_cfg_s'(PGIO_BUSCFG_RST[6:0]);
		end else if (req.wr && req.addr == PGIO_OFS_BUSCFG) begin
			cfg_q.bus_release_enable <= req.wdata[PGIO_CFG_BUS_RELEASE_ENABLE];
			cfg_q.bus_request_out_enable <= req.wdata[PGIO_CFG_BREQOE];
			cfg_q.select4_enable <= req.wdata[PGIO_CFG_SELECT4_ENABLE];
			cfg_q.select_n_enable <= req.wdata[PGIO_CFG_CS3E:PGIO_CFG_CS0E];
		end
	end

	// ==========================================================
	// pin-state view and read port
	genvar gi;
	generate
		for (gi = 0; gi < 7; gi++) begin : g_state
			assign pin_state[gi] = port_direction_bits_q[gi] ? port_output_latch_q[gi]
				: pin_sync_q[gi];
		end
	endgenerate

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= 8'h00;
		end else if (req.rd) begin
			case (req.addr)
				PGIO_OFS_LATCH: reg_rdata <= {1'b0, port_output_latch_q};
				PGIO_OFS_PINS: reg_rdata <= {1'b0, pin_state};
				PGIO_OFS_DIR: reg_rdata <= {1'b0, port_direction_bits_q};
				PGIO_OFS_BUSCFG: reg_rdata <= {1'b0, cfg_q.select_n_enable,
					cfg_q.select4_enable, cfg_q.bus_request_out_enable,
					cfg_q.bus_release_enable};
				PGIO_OFS_MODE: reg_rdata <= {4'h0, external_expansion_enable_q, mode_q};
				default: reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// ==========================================================
	// function multiplexer
	assign ext_bus = is_ext(mode_q, external_expansion_enable_q);
	assign release_on = ext_bus && cfg_q.bus_release_enable;

	always_comb begin
		func_drive = 7'h00;
		func_val = 7'h00;
		gpio_mask = 7'h7F;
		// pin 6: request input, never driven
		if (release_on) begin
			gpio_mask[6] = 1'b0;
		end
		if (release_on) begin
			gpio_mask[5] = 1'b0;
			func_drive[5] = 1'b1;
			func_val[5] = bus_ack;
		end
		if (ext_bus) begin
			if (release_on && cfg_q.bus_request_out_enable) begin
				gpio_mask[4] = 1'b0;
				func_drive[4] = 1'b1;
				func_val[4] = bus_request_out;
			end else if (cfg_q.select4_enable) begin
				gpio_mask[4] = 1'b0;
				func_drive[4] = port_direction_bits_q[4];
				func_val[4] = select_four_req;
			end
			for (int i = 2; i < 4; i++) begin
				if (cfg_q.select_n_enable[i]) begin
					gpio_mask[i] = 1'b0;
					if (dram_area_type[i-2]) begin
						func_drive[i] = 1'b1;
						func_val[i] = row_strobe_req[i-2];
					end else begin
						func_drive[i] = port_direction_bits_q[i];
						func_val[i] = area_select_req[i];
					end
				end
			end
			for (int i = 0; i < 2; i++) begin
				if (cfg_q.select_n_enable[i]) begin
					gpio_mask[i] = 1'b0;
					func_drive[i] = port_direction_bits_q[i];
					func_val[i] = area_select_req[i];
				end
			end
		end
	end

	generate
		for (gi = 0; gi < 7; gi++) begin : g_pin
			assign pin_out_d[gi] = gpio_mask[gi] ? port_output_latch_q[gi] : func_val[gi];
			assign oe_b_d[gi] = gpio_mask[gi] ? ~port_direction_bits_q[gi]
				: ~func_drive[gi];
		end
	endgenerate

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_out <= 7'h00;
			pin_oe_b <= 7'h7F;
			bus_request_in <= 1'b1;
		end else begin
			pin_out <= pin_out_d;
			pin_oe_b <= oe_b_d;
			bus_request_in <= release_on ? pin_sync_q[6] : 1'b1;
		end
	end

	// ==========================================================
	// assertions
	sequence s_latch_write;
		reg_wr && reg_addr == PGIO_OFS_LATCH;
	endsequence

	property p_latch_store;
		@(posedge ref_clk) disable iff (!rst_b)
		s_latch_write |=> port_output_latch_q == $past(reg_wdata[6:0]);
	endproperty
	a_latch_store: assert property (p_latch_store) else $error("latch not stored");

	property p_latch_b7;
		@(posedge ref_clk) disable iff (!rst_b)
		(reg_rd && reg_addr == PGIO_OFS_LATCH) |=> reg_rdata[7] == 1'b0;
	endproperty
	a_latch_b7: assert property (p_latch_b7) else $error("latch bit 7 not zero");

	property p_pins_ro;
		@(posedge ref_clk) disable iff (!rst_b)
		(reg_wr && reg_addr == PGIO_OFS_PINS) |=> $stable(port_output_latch_q) &&
			$stable(port_direction_bits_q);
	endproperty
	a_pins_ro: assert property (p_pins_ro) else $error("pin-state write changed state");

	property p_read_latch;
		@(posedge ref_clk) disable iff (!rst_b)
		(reg_rd && reg_addr == PGIO_OFS_PINS) |=>
			((reg_rdata[6:0] & $past(port_direction_bits_q)) ==
			($past(port_output_latch_q) & $past(port_direction_bits_q)));
	endproperty
	a_read_latch: assert property (p_read_latch) else $error("output pin read wrong");

	property p_read_pin;
		@(posedge ref_clk) disable iff (!rst_b)
		(reg_rd && reg_addr == PGIO_OFS_PINS) |=>
			((reg_rdata[6:0] & ~$past(port_direction_bits_q)) ==
			($past(pin_sync_q) & ~$past(port_direction_bits_q)));
	endproperty
	a_read_pin: assert property (p_read_pin) else $error("input pin read wrong");

	property p_req_in;
		@(posedge ref_clk) disable iff (!rst_b)
		release_on |=> pin_oe_b[6] && bus_request_in == $past(pin_sync_q[6]);
	endproperty
	a_req_in: assert property (p_req_in) else $error("request input wrong");

	property p_ack_out;
		@(posedge ref_clk) disable iff (!rst_b)
		release_on |=> !pin_oe_b[5] && pin_out[5] == $past(bus_ack);
	endproperty
	a_ack_out: assert property (p_ack_out) else $error("acknowledge not driven");

	property p_reqo;
		@(posedge ref_clk) disable iff (!rst_b)
		(release_on && cfg_q.bus_request_out_enable) |=>
			!pin_oe_b[4] && pin_out[4] == $past(bus_request_out);
	endproperty
	a_reqo: assert property (p_reqo) else $error("request output wrong");

	property p_gpio_only;
		@(posedge ref_clk) disable iff (!rst_b)
		!ext_bus |=> pin_oe_b == ~$past(port_direction_bits_q) &&
			pin_out == $past(port_output_latch_q);
	endproperty
	a_gpio_only: assert property (p_gpio_only) else $error("single-chip pins wrong");

	sequence s_strap_taken;
		!strap_done_q ##1 strap_done_q;
	endsequence

	// pin 0 direction follows the captured mode; the rest start as inputs
	property p_dir_boot;
		@(posedge ref_clk) disable iff (!rst_b)
		s_strap_taken |-> port_direction_bits_q[PGIO_PIN0] == ((mode_q == PGIO_MODE1) ||
			(mode_q == PGIO_MODE2)) && port_direction_bits_q[6:1] == 6'h00;
	endproperty
	a_dir_boot: assert property (p_dir_boot) else $error("direction reset wrong");

	property p_sel_four;
		@(posedge ref_clk) disable iff (!rst_b)
		(ext_bus && cfg_q.select4_enable &&
			!(release_on && cfg_q.bus_request_out_enable)) |=>
			pin_oe_b[4] == !$past(port_direction_bits_q[4]) &&
			pin_out[4] == $past(select_four_req);
	endproperty
	a_sel_four: assert property (p_sel_four) else $error("select four wrong");

	property p_row_two;
		@(posedge ref_clk) disable iff (!rst_b)
		(ext_bus && cfg_q.select_n_enable[2] && dram_area_type[0]) |=>
			!pin_oe_b[2] && pin_out[2] == $past(row_strobe_req[0]);
	endproperty
	a_row_two: assert property (p_row_two) else $error("row strobe wrong");

	property p_sel_three;
		@(posedge ref_clk) disable iff (!rst_b)
		(ext_bus && cfg_q.select_n_enable[3] && !dram_area_type[1]) |=>
			pin_oe_b[3] == !$past(port_direction_bits_q[3]) &&
			pin_out[3] == $past(area_select_req[3]);
	endproperty
	a_sel_three: assert property (p_sel_three) else $error("select three wrong");

	property p_sel_zero;
		@(posedge ref_clk) disable iff (!rst_b)
		(ext_bus && cfg_q.select_n_enable[0]) |=>
			pin_oe_b[0] == !$past(port_direction_bits_q[0]) &&
			pin_out[0] == $past(area_select_req[0]);
	endproperty
	a_sel_zero: assert property (p_sel_zero) else $error("select zero wrong");

	property p_sel_one;
		@(posedge ref_clk) disable iff (!rst_b)
		(ext_bus && cfg_q.select_n_enable[1]) |=>
			pin_oe_b[1] == !$past(port_direction_bits_q[1]) &&
			pin_out[1] == $past(area_select_req[1]);
	endproperty
	a_sel_one: assert property (p_sel_one) else $error("select one wrong");

	property p_pins_b7;
		@(posedge ref_clk) disable iff (!rst_b)
		(reg_rd && reg_addr == PGIO_OFS_PINS) |=> reg_rdata[7] == 1'b0;
	endproperty
	a_pins_b7: assert property (p_pins_b7) else $error("pin-state bit 7 not zero");

	// read data stand for one cycle only, then return to zero
	property p_rdata_idle;
		@(posedge ref_clk) disable iff (!rst_b)
		!reg_rd |=> reg_rdata == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not cleared");
endmodule
`default_nettype wire
